/* core/pmd_pkg.sv */
// package for the mailbox and doorbell block: register indices, reset values, carriers
// assumes both register ports share clk_sys and a synchronous active-high reset
package pmd_pkg;

  localparam int unsigned DATA_W    = 32;
  localparam int unsigned ADDR_W    = 3;
  localparam int unsigned BE_W      = 4;
  localparam int unsigned MBOX_N    = 4;

  // register indices, shared by the core port and the pci port
  localparam logic [2:0] IDX_MBOX0      = 3'h0;
  localparam logic [2:0] IDX_MBOX1      = 3'h1;
  localparam logic [2:0] IDX_MBOX2      = 3'h2;
  localparam logic [2:0] IDX_MBOX3      = 3'h3;
  localparam logic [2:0] IDX_CORE_DB    = 3'h4;
  localparam logic [2:0] IDX_CORE_SETUP = 3'h5;
  localparam logic [2:0] IDX_PCI_DB     = 3'h6;
  localparam logic [2:0] IDX_PCI_SETUP  = 3'h7;

  // deasserted values: core-bound idles at all ones, pci-bound at all zeros
  localparam logic [31:0] CORE_DB_RESET = 32'hffffffff;
  localparam logic [31:0] PCI_DB_RESET  = 32'h00000000;
  localparam logic [31:0] MBOX_RESET    = 32'h00000000;

  // silicon revision codes for general interrupt routing
  localparam logic REV_FIRST = 1'h0;
  localparam logic REV_LATER = 1'h1;

  // one register access from either side
  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [2:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pmd_req_type;

  typedef struct packed {
    logic        rd_valid;
    logic [31:0] rdata;
  } pmd_rsp_type;

  // other sources of the pci interrupt pin
  typedef struct packed {
    logic       dma_done;
    logic       pci_int_request_bit;
    logic       unit_event;
    logic       general_irq;
  } pmd_int_src_type;

endpackage

/* core/pmd_mailbox_doorbell.sv */
// mailbox and doorbell block between the embedded control core and the pci agent
// assumes both request ports are synchronous to clk_sys; one access per port per cycle
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - four 32-bit mailboxes, byte-writable and readable from both core and pci ports.
// - mailbox values are only stored and returned, never interpreted.
// - pci writes to core-bound doorbell raise the fast core interrupt.
// - core writes to pci-bound doorbell raise the pci interrupt.
// - each doorbell pattern reduces to one interrupt and stays readable.
// - 32 set/reset bits; core ones set, pci ones clear.
// - zero bits written to a doorbell leave those bits unchanged.
// - pci interrupt line is the nor of all pci-bound doorbell bits.
// - a raise drives the bit to 0 core-bound, 1 pci-bound.
// - a dismiss drives the bit to 1 core-bound, 0 pci-bound.
// - setup registers write straight into doorbell bits, overwriting them.
// - setup lets the raising side withdraw its own interrupt.
// - setup lets a side raise a doorbell aimed at itself, for diagnostics.
// - pci pin asserts on doorbell, dma done, request bit clear, or unit event.
// - first revision routes general requests to core; later revision may route to pci.
module pmd_mailbox_doorbell
  import pmd_pkg::*;
#(
  parameter logic SILICON_REV = pmd_pkg::REV_LATER
)
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire pmd_pkg::pmd_req_type     core_req,
  output var  pmd_pkg::pmd_rsp_type     core_rsp,
  input  wire pmd_pkg::pmd_req_type     pci_req,
  output var  pmd_pkg::pmd_rsp_type     pci_rsp,
  input  wire pmd_pkg::pmd_int_src_type int_src,
  input  wire logic                     general_to_pci,
  output logic                          fast_core_interrupt,
  output logic                          core_general_irq,
  output logic                          pci_int_n
);
  import pmd_pkg::*;

  logic [31:0] mbox_q [MBOX_N];
  logic [31:0] core_db_q;
  logic [31:0] core_db_d;
  logic [31:0] pci_db_q;
  logic [31:0] pci_db_d;
  // write strobes, one bit per register index, and byte-lane masks per port
  logic [7:0]  core_wr_hit;
  logic [7:0]  pci_wr_hit;
  logic [31:0] core_lanes;
  logic [31:0] pci_lanes;
  // ones written through the plain doorbell indices, already masked by lanes
  logic [31:0] core_db_raise;
  logic [31:0] core_db_dismiss;
  logic [31:0] pci_db_raise;
  logic [31:0] pci_db_dismiss;
  // pin sources, active high, kept apart so each one can be traced alone
  logic        pin_from_db;
  logic        pin_from_dma;
  logic        pin_from_ctl;
  logic        pin_from_unit;
  logic        pin_from_gen;
  logic        gen_to_pci_en;
  logic        gen_to_core;

  // expand byte enables into a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  function automatic logic is_wr(input pmd_req_type r, input logic [2:0] idx);
    return r.wr_en && (r.addr == idx);
  endfunction

  // byte-lane merge: enabled lanes take the written data, the others keep the old value
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
    logic [31:0] m;
    m = be_mask(be);
    return (old_v & ~m) | (new_v & m);
  endfunction

  // one strobe per register index; a read alone never strobes
  function automatic logic [7:0] wr_decode(input pmd_req_type r);
    logic [7:0] hit;
    hit = '0;
    for (int i = 0; i < 8; i++)
    begin
      hit[i] = is_wr(r, ADDR_W'(i));
    end
    return hit;
  endfunction

  // decoded once per port so every register block sees the same strobes
  always_comb
  begin
    core_wr_hit = wr_decode(core_req);
    pci_wr_hit  = wr_decode(pci_req);
    core_lanes  = be_mask(core_req.be);
    pci_lanes   = be_mask(pci_req.be);
  end

  // plain doorbell writes: only ones count, zeros leave bits alone
  always_comb
  begin
    core_db_raise   = pci_wr_hit[IDX_CORE_DB] ? (pci_req.wdata & pci_lanes) : '0;
    core_db_dismiss = core_wr_hit[IDX_CORE_DB] ? (core_req.wdata & core_lanes) : '0;
    pci_db_raise    = core_wr_hit[IDX_PCI_DB] ? (core_req.wdata & core_lanes) : '0;
    pci_db_dismiss  = pci_wr_hit[IDX_PCI_DB] ? (pci_req.wdata & pci_lanes) : '0;
  end

  // mailboxes: plain storage, byte lanes; pci wins a same-lane collision
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int k = 0; k < MBOX_N; k++)
      begin
        mbox_q[k] <= MBOX_RESET;
      end
    end
    else
    begin
      for (int k = 0; k < MBOX_N; k++)
      begin
        logic [31:0] v;
        v = mbox_q[k];
        if (core_wr_hit[k])
        begin
          v = lane_merge(v, core_req.wdata, core_req.be);
        end
        if (pci_wr_hit[k])
        begin
          v = lane_merge(v, pci_req.wdata, pci_req.be);
        end
        mbox_q[k] <= v;
      end
    end
  end

  // core-bound doorbell: pci ones raise (drive 0), core ones dismiss (drive 1)
  always_comb
  begin
    core_db_d = core_db_q;
    core_db_d = core_db_d & ~core_db_raise;
    core_db_d = core_db_d | core_db_dismiss;  // a dismiss in the same cycle as a raise wins
    // setup writes overwrite the addressed lanes; pci setup applied last
    if (core_wr_hit[IDX_CORE_SETUP])
    begin
      core_db_d = lane_merge(core_db_d, core_req.wdata, core_req.be);
    end
    if (pci_wr_hit[IDX_CORE_SETUP])
    begin
      core_db_d = lane_merge(core_db_d, pci_req.wdata, pci_req.be);
    end
  end

  // pci-bound doorbell: core ones raise (set), pci ones dismiss (clear)
  always_comb
  begin
    pci_db_d = pci_db_q;
    // a raise in the same cycle as a dismiss of the same bit wins
    pci_db_d = (pci_db_d & ~pci_db_dismiss) | pci_db_raise;
    if (pci_wr_hit[IDX_PCI_SETUP])
    begin
      pci_db_d = lane_merge(pci_db_d, pci_req.wdata, pci_req.be);
    end
    if (core_wr_hit[IDX_PCI_SETUP])
    begin
      pci_db_d = lane_merge(pci_db_d, core_req.wdata, core_req.be);
    end
  end

  // doorbells only move on a write; nothing else in the block touches them
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      core_db_q <= CORE_DB_RESET;
    end
    else
    begin
      core_db_q <= core_db_d;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pci_db_q <= PCI_DB_RESET;
    end
    else
    begin
      pci_db_q <= pci_db_d;
    end
  end

  // read mux, shared by both ports; doorbells read back raw
  function automatic logic [31:0] rd_mux(input logic [2:0] a);
    logic [31:0] r;
    r = '0;
    case (a)
      IDX_MBOX0, IDX_MBOX1, IDX_MBOX2, IDX_MBOX3: r = mbox_q[a[1:0]];
      IDX_CORE_DB, IDX_CORE_SETUP:                r = core_db_q;
      IDX_PCI_DB, IDX_PCI_SETUP:                  r = pci_db_q;
      default:                                    r = '0;
    endcase
    return r;
  endfunction

  // read data is one cycle after the request, held until the next read
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      core_rsp <= '0;
    end
    else
    begin
      core_rsp.rd_valid <= core_req.rd_en;
      if (core_req.rd_en)
      begin
        core_rsp.rdata <= rd_mux(core_req.addr);
      end
    end
  end

  // the pci port has its own register so both sides may read in one cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pci_rsp <= '0;
    end
    else
    begin
      pci_rsp.rd_valid <= pci_req.rd_en;
      if (pci_req.rd_en)
      begin
        pci_rsp.rdata <= rd_mux(pci_req.addr);
      end
    end
  end

  // general requests: the first revision has no path from them to the pci pin
  always_comb
  begin
    gen_to_pci_en = (SILICON_REV == REV_LATER) && general_to_pci;
    gen_to_core   = int_src.general_irq && !gen_to_pci_en;
  end

  // every source that may pull the pci pin low
  always_comb
  begin
    pin_from_db   = |pci_db_d;
    pin_from_dma  = int_src.dma_done;
    pin_from_ctl  = !int_src.pci_int_request_bit;
    pin_from_unit = int_src.unit_event;
    pin_from_gen  = int_src.general_irq && gen_to_pci_en;
  end

  // interrupts registered from the next doorbell value so they track it exactly;
  // this costs no latency beyond the register write itself
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      fast_core_interrupt <= 1'b0;
    end
    else
    begin
      fast_core_interrupt <= ~(&core_db_d);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      core_general_irq <= 1'b0;
    end
    else
    begin
      core_general_irq <= gen_to_core;
    end
  end

  // active low pin: the nor of the doorbell bits merged with the other sources
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pci_int_n <= 1'b1;
    end
    else
    begin
      pci_int_n <= !(pin_from_db || pin_from_dma || pin_from_ctl
                     || pin_from_unit || pin_from_gen);
    end
  end

endmodule
`default_nettype wire

/* tb/pmd_assertions.sv */
// checker for the mailbox and doorbell block, bound to its top module
// assumes one clock, reset synchronous active high
`timescale 1ns/1ps
`default_nettype none
module pmd_assertions
  import pmd_pkg::*;
#(
  parameter logic SILICON_REV = REV_LATER
)
(
  input wire logic                     clk_sys,
  input wire logic                     rst,
  input wire pmd_pkg::pmd_req_type     core_req,
  input wire pmd_pkg::pmd_rsp_type     core_rsp,
  input wire pmd_pkg::pmd_req_type     pci_req,
  input wire pmd_pkg::pmd_rsp_type     pci_rsp,
  input wire pmd_pkg::pmd_int_src_type int_src,
  input wire logic                     general_to_pci,
  input wire logic                     fast_core_interrupt,
  input wire logic                     core_general_irq,
  input wire logic                     pci_int_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // same-cycle writes from the other port may win, so they are left out
  wire logic up_core = pci_req.wr_en && pci_req.addr == IDX_CORE_DB && pci_req.be == 4'hf && |pci_req.wdata
    && !(core_req.wr_en && core_req.addr[2:1] == 2'h2);
  wire logic up_pci = core_req.wr_en && core_req.addr == IDX_PCI_DB && core_req.be == 4'hf && |core_req.wdata
    && !(pci_req.wr_en && pci_req.addr == IDX_PCI_SETUP);
  wire logic calm = core_req.wr_en && core_req.addr == IDX_CORE_SETUP && core_req.be == 4'hf && &core_req.wdata
    && !(pci_req.wr_en && pci_req.addr[2:1] == 2'h2);
  chk_core_rd_lat: assert property (core_req.rd_en |=> core_rsp.rd_valid)
    else $error("core read late");
  chk_pci_rd_lat: assert property ($rose(pci_req.rd_en) |=> $rose(pci_rsp.rd_valid))
    else $error("pci read late");
  chk_pci_raise: assert property (up_pci |=> !pci_int_n)
    else $error("pci pin not low");
  chk_core_raise: assert property (up_core |=> fast_core_interrupt)
    else $error("fast interrupt missing");
  chk_setup_calm: assert property (calm |=> !fast_core_interrupt)
    else $error("setup left interrupt");
  chk_pin_sources: assert property (
    int_src.dma_done || int_src.unit_event || !int_src.pci_int_request_bit |=> !pci_int_n)
    else $error("pin source ignored");
  chk_general_core: assert property (int_src.general_irq && !general_to_pci |=> core_general_irq)
    else $error("general not at core");
  chk_general_pci: assert property (
    int_src.general_irq && general_to_pci && SILICON_REV == REV_LATER |=> !pci_int_n && !core_general_irq)
    else $error("general not at pci");
  chk_general_first: assert property (
    int_src.general_irq && SILICON_REV == REV_FIRST |=> core_general_irq)
    else $error("first revision general not at core");
  cover property (up_core);
  cover property (up_pci);
  cover property (calm);
endmodule
bind pmd_mailbox_doorbell pmd_assertions #(.SILICON_REV(SILICON_REV)) pmd_assertions_i (.clk_sys(clk_sys),
  .rst(rst), .core_req(core_req), .core_rsp(core_rsp), .pci_req(pci_req), .pci_rsp(pci_rsp), .int_src(int_src),
  .general_to_pci(general_to_pci), .fast_core_interrupt(fast_core_interrupt),
  .core_general_irq(core_general_irq), .pci_int_n(pci_int_n));
`default_nettype wire

/* tb/pmd_port_agent.sv */
// register port agent: the pci agent, or the core in a second instance
// assumes clk_sys is the block clock
`timescale 1ns/1ps
`default_nettype none
module pmd_port_agent
  import pmd_pkg::*;
(
  input  wire logic                 clk_sys,
  output var  pmd_pkg::pmd_req_type req
);
  initial req = '0;
  task automatic xfer(input pmd_req_type r);
    @(posedge clk_sys);
    #1 req = r;
    @(posedge clk_sys);
    // idle lines show the inverse, so a stale value never looks valid
    #1 req = {2'h0, ~r.addr, ~r.be, ~r.wdata};
  endtask
endmodule
`default_nettype wire

/* tb/pmd_mailbox_doorbell_tb_top.sv */
// self-checking bench for the mailbox and doorbell block
// assumes the checker binds itself
`timescale 1ns/1ps
`default_nettype none
module pmd_mailbox_doorbell_tb_top;
  import pmd_pkg::*;
  logic            clk_sys = 0;
  logic            rst = 1;
  pmd_req_type     core_req, pci_req;
  pmd_rsp_type     core_rsp, pci_rsp;
  pmd_int_src_type int_src = 4'h4;
  logic            gen_pci = 0;
  logic            fast, gen_irq, pin_n, fast1, gen_irq1, pin1_n;
  logic [31:0]     qc[$], qp[$], rnd = 32'haa69, x;
  logic [7:0]      tbl[5] = '{8'hc0, 8'h00, 8'h60, 8'h53, 8'h58};
  int              bad_count = 0, n_checks = 0;
  pmd_mailbox_doorbell pmd_mailbox_doorbell_i (.clk_sys(clk_sys), .rst(rst), .core_req(core_req),
    .core_rsp(core_rsp), .pci_req(pci_req), .pci_rsp(pci_rsp), .int_src(int_src), .general_to_pci(gen_pci),
    .fast_core_interrupt(fast), .core_general_irq(gen_irq), .pci_int_n(pin_n));
  // first-revision copy: same stimulus, only its interrupt outputs are compared
  pmd_mailbox_doorbell #(.SILICON_REV(REV_FIRST)) pmd_mailbox_doorbell_first_i (.clk_sys(clk_sys), .rst(rst),
    .core_req(core_req), .core_rsp(), .pci_req(pci_req), .pci_rsp(), .int_src(int_src), .general_to_pci(gen_pci),
    .fast_core_interrupt(fast1), .core_general_irq(gen_irq1), .pci_int_n(pin1_n));
  pmd_port_agent core_agent_i (.clk_sys(clk_sys), .req(core_req));
  pmd_port_agent pci_agent_i (.clk_sys(clk_sys), .req(pci_req));
  initial forever #4 clk_sys = ~clk_sys;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tally(input bit ok, input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (!ok)
    begin
      bad_count++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic chk_rd(input logic [31:0] e, input logic [31:0] s);
    tally(s === e, "rdata", e, s);
  endtask
  task automatic chk_pins(input logic [2:0] e);
    tally({fast, gen_irq, pin_n} === e, "pins", 32'(e), 32'({fast, gen_irq, pin_n}));
  endtask
  task automatic chk_first(input logic [2:0] e);
    tally({fast1, gen_irq1, pin1_n} === e, "first rev pins", 32'(e), 32'({fast1, gen_irq1, pin1_n}));
  endtask
  // a read carries its expected data in d
  task automatic acc(input bit p, input bit w, input logic [2:0] a, input logic [3:0] be, input logic [31:0] d);
    if (!w && p) qp.push_back(d);
    if (!w && !p) qc.push_back(d);
    if (p) pci_agent_i.xfer({w, !w, a, be, d});
    else core_agent_i.xfer({w, !w, a, be, d});
  endtask
  task automatic complete_run;
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(negedge clk_sys)
  begin
    if (core_rsp.rd_valid === 1'b1) chk_rd(qc.size() > 0 ? qc.pop_front() : 32'hx, core_rsp.rdata);
    if (pci_rsp.rd_valid === 1'b1) chk_rd(qp.size() > 0 ? qp.pop_front() : 32'hx, pci_rsp.rdata);
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    #1 rst = 0;
    chk_pins(3'h1);
    chk_first(3'h1);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      x = lfsr(rnd);
      acc(0, 1, 3'(i), 4'hf, rnd);
      acc(1, 1, 3'(i), 4'h2, x);
      acc(1, 0, 3'(i), 4'h0, {rnd[31:16], x[15:8], rnd[7:0]});
      acc(0, 0, 3'(i), 4'h0, {rnd[31:16], x[15:8], rnd[7:0]});
      rnd = x;
    end
    acc(0, 1, 6, 4'hf, 32'h5);
    chk_pins(3'h0);
    acc(1, 1, 6, 4'hf, 32'h1);
    chk_pins(3'h0);
    acc(1, 0, 6, 4'h0, 32'h4);
    acc(1, 1, 6, 4'hf, 32'h4);
    chk_pins(3'h1);
    acc(1, 1, 4, 4'hf, 32'h80000000);
    chk_pins(3'h5);
    acc(0, 0, 4, 4'h0, 32'h7fffffff);
    acc(0, 1, 4, 4'hf, 32'h80000000);
    chk_pins(3'h1);
    acc(0, 1, 6, 4'hf, 32'h1);
    acc(0, 1, 7, 4'hf, 32'h0);
    chk_pins(3'h1);
    acc(0, 1, 5, 4'hf, 32'hfffffffe);
    chk_pins(3'h5);
    acc(0, 0, 5, 4'h0, 32'hfffffffe);
    acc(0, 1, 5, 4'hf, 32'hffffffff);
    chk_pins(3'h1);
    for (int k = 0; k < 5; k++)
    begin
      @(posedge clk_sys);
      #1 {int_src, gen_pci} = tbl[k][7:3];
      @(posedge clk_sys);
      #1 chk_pins(tbl[k][2:0]);
      chk_first(k == 4 ? 3'h3 : tbl[k][2:0]);
    end
    for (int t = 0; t < 20 && qc.size() + qp.size() > 0; t++) @(posedge clk_sys);
    if (qc.size() + qp.size() > 0) bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
